/* File: rtl/pin_mux_pkg.sv */
/*
 * Shared constants and types for the port pin override multiplexer.
 * Assumes an eight-pin port on one clock with an APB register slave.
 */
package pin_mux_pkg;

    // ==========================================================
    // Port geometry and register map
    // ==========================================================
    localparam int PORT_WIDTH = 8;
    localparam logic [11:0] DIR_OFFSET = 12'h000;
    localparam logic [11:0] LATCH_OFFSET = 12'h004;
    localparam logic [11:0] SAMPLE_OFFSET = 12'h008;
    localparam logic [11:0] CTRL_OFFSET = 12'h00C;
    localparam logic [11:0] STATUS_OFFSET = 12'h010;
    localparam int CTRL_PULLUP_DISABLE_BIT = 0;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic CTRL_PULLUP_DISABLE_RESET = 1'b0;
    localparam logic [2:0] PULLUP_PATTERN = 3'h2;

    // ==========================================================
    // Alternate function pin positions
    // ==========================================================
    localparam int CAPTURE_BIT = 0;
    localparam int CLKOUT_BIT = 0;
    localparam int T1_CMP_A_BIT = 1;
    localparam int T1_CMP_B_BIT = 2;
    localparam int SPI_SS_BIT = 2;
    localparam int T2_CMP_A_BIT = 3;
    localparam int SPI_MOSI_BIT = 3;
    localparam int OSC_PIN1_BIT = 6;
    localparam int OSC_PIN2_BIT = 7;

    // ==========================================================
    // Override bundle presented by a peripheral for one pin
    // ==========================================================
    typedef struct packed {
        logic pullup_override_en;
        logic pullup_override_val;
        logic dir_override_en;
        logic dir_override_val;
        logic value_override_en;
        logic value_override_val;
        logic toggle_override_en;
        logic input_en_override_en;
        logic input_en_override_val;
    } pin_override_t;

    typedef struct packed {
        logic pullup_en;
        logic drive_en;
        logic drive_val;
        logic input_en;
    } pin_resolved_t;

endpackage : pin_mux_pkg

/* File: rtl/pin_override_cell.sv */
/*
 * Combinational resolution of one pin's pull-up, driver and input enable.
 * Assumes registered software bits and a merged override bundle.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_override_cell
(
    input wire pin_mux_pkg::pin_override_t ovr_i,
    input wire logic direction_bit_i,
    input wire logic output_latch_bit_i,
    input wire logic global_pullup_disable_i,
    input wire logic deep_sleep_i,
    output pin_mux_pkg::pin_resolved_t res_o
);

    // ==========================================================
    // Resolution
    // ==========================================================
    always_comb
    begin
        if (ovr_i.pullup_override_en)
        begin
            res_o.pullup_en = ovr_i.pullup_override_val;
        end
        else
        begin
            res_o.pullup_en = ({direction_bit_i, output_latch_bit_i, global_pullup_disable_i}
                               == pin_mux_pkg::PULLUP_PATTERN);
        end
        if (ovr_i.dir_override_en)
        begin
            res_o.drive_en = ovr_i.dir_override_val;
        end
        else
        begin
            res_o.drive_en = direction_bit_i;
        end
        if (ovr_i.value_override_en)
        begin
            res_o.drive_val = ovr_i.value_override_val;
        end
        else
        begin
            res_o.drive_val = output_latch_bit_i;
        end
        if (ovr_i.input_en_override_en)
        begin
            res_o.input_en = ovr_i.input_en_override_val;
        end
        else
        begin
            res_o.input_en = ~deep_sleep_i;
        end
    end

endmodule : pin_override_cell

`default_nettype wire

/* File: rtl/port_pin_override_mux.sv */
/*
 * Eight-pin port with alternate function override multiplexing and APB registers.
 * Assumes pad inputs are asynchronous and peripherals supply their own override bundles.
 */
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Pull-up override enable high makes pull-up follow the override value while the driver is off.
// - Otherwise pull-up is on only for direction, latch, disable equal 010.
// - Direction override enable high makes driver enable equal override value.
// - Otherwise the software direction bit enables the driver.
// - Value override enable high drives the override value onto the pin while the driver is enabled.
// - Otherwise the driven level follows the output latch bit.
// - Toggle override enable inverts the stored output latch bit.
// - Input enable override enable high sets input enable from override value.
// - Otherwise input is enabled normally and clamped in deep sleep.
// - Raw input to peripherals is taken after clamp, before the synchronizer.
// - The analog path connects straight to the pad.
// - Each port bit n is pin change source n.
// - Bit 3 carries SPI MOSI and timer2 compare A; bit 2 SPI SS and timer1 compare B.
// - Bit 1 carries timer1 compare A; bit 0 capture input and divided clock.
// - Bits 7 and 6 are main and timer oscillator pins 2 and 1.
// - Direction bit one makes an output, zero an input.
// - Writing one to an input register bit toggles the output latch bit.

module port_pin_override_mux
#(
    parameter int WIDTH = pin_mux_pkg::PORT_WIDTH
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire pin_mux_pkg::pin_override_t [WIDTH-1:0] ovr_i,
    input wire logic deep_sleep_i,
    input wire logic timer2_cmp_a_en_i,
    input wire logic timer2_cmp_a_out_i,
    input wire logic timer1_cmp_a_en_i,
    input wire logic timer1_cmp_a_out_i,
    input wire logic timer1_cmp_b_en_i,
    input wire logic timer1_cmp_b_out_i,
    input wire logic divided_clock_en_i,
    input wire logic divided_clock_out_i,
    input wire logic [WIDTH-1:0] pad_in_i,
    output logic [WIDTH-1:0] pad_out_o,
    output logic [WIDTH-1:0] pad_oe_o,
    output logic [WIDTH-1:0] pullup_en_o,
    output logic [WIDTH-1:0] raw_digital_in_o,
    output logic [WIDTH-1:0] pin_change_src_o,
    output logic timer1_capture_in_o,
    output logic spi_mosi_in_o,
    output logic spi_ss_in_o,
    output logic [WIDTH-1:0] analog_pad_path_o,
    output logic main_osc_pin1_o,
    output logic main_osc_pin2_o,
    output logic timer_osc_pin1_o,
    output logic timer_osc_pin2_o
);

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [WIDTH-1:0] dir_reg;
    logic [WIDTH-1:0] dir_next;
    logic [WIDTH-1:0] latch_reg;
    logic [WIDTH-1:0] latch_next;
    logic pullup_disable_reg;
    logic pullup_disable_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage1_next;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage2_next;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] stage3_next;
    logic [WIDTH-1:0] sample_reg;
    logic [WIDTH-1:0] sample_next;
    logic [WIDTH-1:0] raw_reg;
    logic [WIDTH-1:0] raw_next;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;
    logic [WIDTH-1:0] oe_reg;
    logic [WIDTH-1:0] oe_next;
    logic [WIDTH-1:0] pu_reg;
    logic [WIDTH-1:0] pu_next;
    logic [WIDTH-1:0] ie_reg;
    logic [WIDTH-1:0] ie_next;
    logic [WIDTH-1:0] toggle_req;
    logic [WIDTH-1:0] gated_in;
    logic access_done;
    logic addr_mapped;
    pin_mux_pkg::pin_override_t [WIDTH-1:0] merged_ovr;
    pin_mux_pkg::pin_resolved_t [WIDTH-1:0] resolved;

    // ==========================================================
    // Override merging and per-pin resolution
    // ==========================================================
    // Timer compare outputs only replace the value; the direction bit must still be set by software.
    always_comb
    begin
        merged_ovr = ovr_i;
        if (timer2_cmp_a_en_i)
        begin
            merged_ovr[pin_mux_pkg::T2_CMP_A_BIT].value_override_en = 1'b1;
            merged_ovr[pin_mux_pkg::T2_CMP_A_BIT].value_override_val = timer2_cmp_a_out_i;
        end
        if (timer1_cmp_b_en_i)
        begin
            merged_ovr[pin_mux_pkg::T1_CMP_B_BIT].value_override_en = 1'b1;
            merged_ovr[pin_mux_pkg::T1_CMP_B_BIT].value_override_val = timer1_cmp_b_out_i;
        end
        if (timer1_cmp_a_en_i)
        begin
            merged_ovr[pin_mux_pkg::T1_CMP_A_BIT].value_override_en = 1'b1;
            merged_ovr[pin_mux_pkg::T1_CMP_A_BIT].value_override_val = timer1_cmp_a_out_i;
        end
        if (divided_clock_en_i)
        begin
            merged_ovr[pin_mux_pkg::CLKOUT_BIT].dir_override_en = 1'b1;
            merged_ovr[pin_mux_pkg::CLKOUT_BIT].dir_override_val = 1'b1;
            merged_ovr[pin_mux_pkg::CLKOUT_BIT].value_override_en = 1'b1;
            merged_ovr[pin_mux_pkg::CLKOUT_BIT].value_override_val = divided_clock_out_i;
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_pin
            pin_override_cell u_cell
            (
                .ovr_i(merged_ovr[g]),
                .direction_bit_i(dir_reg[g]),
                .output_latch_bit_i(latch_reg[g]),
                .global_pullup_disable_i(pullup_disable_reg),
                .deep_sleep_i(deep_sleep_i),
                .res_o(resolved[g])
            );
            assign toggle_req[g] = merged_ovr[g].toggle_override_en;
            assign gated_in[g] = pad_in_i[g] & resolved[g].input_en;
        end
    endgenerate

    // ==========================================================
    // Pad drive, pull-up and input path
    // ==========================================================
    // Pad controls are registered, so they follow their causes by one clock.
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            oe_next[i] = resolved[i].drive_en;
            out_next[i] = resolved[i].drive_en & resolved[i].drive_val;
            pu_next[i] = resolved[i].pullup_en & ~resolved[i].drive_en;
            ie_next[i] = resolved[i].input_en;
        end
        raw_next = gated_in;
        stage1_next = gated_in;
        stage2_next = stage1_reg;
        stage3_next = stage2_reg;
        sample_next = sample_reg;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (stage2_reg[i] == stage3_reg[i])
            begin
                sample_next[i] = stage3_reg[i];
            end
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            oe_reg <= '0;
            out_reg <= '0;
            pu_reg <= '0;
            ie_reg <= '0;
            raw_reg <= '0;
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            sample_reg <= '0;
        end
        else
        begin
            oe_reg <= oe_next;
            out_reg <= out_next;
            pu_reg <= pu_next;
            ie_reg <= ie_next;
            raw_reg <= raw_next;
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
            stage3_reg <= stage3_next;
            sample_reg <= sample_next;
        end
    end

    // ==========================================================
    // APB slave and software registers
    // ==========================================================
    assign access_done = psel_i & penable_i & pready_reg;
    assign addr_mapped = (paddr_i == pin_mux_pkg::DIR_OFFSET) || (paddr_i == pin_mux_pkg::LATCH_OFFSET) ||
                         (paddr_i == pin_mux_pkg::SAMPLE_OFFSET) || (paddr_i == pin_mux_pkg::CTRL_OFFSET) ||
                         (paddr_i == pin_mux_pkg::STATUS_OFFSET);

    always_comb
    begin
        dir_next = dir_reg;
        latch_next = latch_reg;
        pullup_disable_next = pullup_disable_reg;
        pready_next = psel_i & ~penable_i;
        pslverr_next = psel_i & ~penable_i & ~addr_mapped;
        prdata_next = prdata_reg;
        if (psel_i && !penable_i)
        begin
            prdata_next = 32'h0000_0000;
            case (paddr_i)
                pin_mux_pkg::DIR_OFFSET: prdata_next[WIDTH-1:0] = dir_reg;
                pin_mux_pkg::LATCH_OFFSET: prdata_next[WIDTH-1:0] = latch_reg;
                pin_mux_pkg::SAMPLE_OFFSET: prdata_next[WIDTH-1:0] = sample_reg;
                pin_mux_pkg::CTRL_OFFSET: prdata_next[pin_mux_pkg::CTRL_PULLUP_DISABLE_BIT] = pullup_disable_reg;
                pin_mux_pkg::STATUS_OFFSET: prdata_next[WIDTH-1:0] = ie_reg;
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        if (access_done && pwrite_i)
        begin
            case (paddr_i)
                pin_mux_pkg::DIR_OFFSET: dir_next = pwdata_i[WIDTH-1:0];
                pin_mux_pkg::LATCH_OFFSET: latch_next = pwdata_i[WIDTH-1:0];
                pin_mux_pkg::SAMPLE_OFFSET: latch_next = latch_reg ^ pwdata_i[WIDTH-1:0];
                pin_mux_pkg::CTRL_OFFSET: pullup_disable_next = pwdata_i[pin_mux_pkg::CTRL_PULLUP_DISABLE_BIT];
                default: pullup_disable_next = pullup_disable_reg;
            endcase
        end
        // A peripheral toggle lands on top of any software write in the same cycle.
        latch_next = latch_next ^ toggle_req;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dir_reg <= pin_mux_pkg::DIR_RESET;
            latch_reg <= pin_mux_pkg::LATCH_RESET;
            pullup_disable_reg <= pin_mux_pkg::CTRL_PULLUP_DISABLE_RESET;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            dir_reg <= dir_next;
            latch_reg <= latch_next;
            pullup_disable_reg <= pullup_disable_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign pad_out_o = out_reg;
    assign pad_oe_o = oe_reg;
    assign pullup_en_o = pu_reg;
    assign raw_digital_in_o = raw_reg;
    assign pin_change_src_o = raw_reg;
    assign timer1_capture_in_o = raw_reg[pin_mux_pkg::CAPTURE_BIT];
    assign spi_mosi_in_o = raw_reg[pin_mux_pkg::SPI_MOSI_BIT];
    assign spi_ss_in_o = raw_reg[pin_mux_pkg::SPI_SS_BIT];
    // The analog path is a wire by nature; a flip-flop here would break the analog signal.
    assign analog_pad_path_o = pad_in_i;
    assign main_osc_pin1_o = pad_in_i[pin_mux_pkg::OSC_PIN1_BIT];
    assign main_osc_pin2_o = pad_in_i[pin_mux_pkg::OSC_PIN2_BIT];
    assign timer_osc_pin1_o = pad_in_i[pin_mux_pkg::OSC_PIN1_BIT];
    assign timer_osc_pin2_o = pad_in_i[pin_mux_pkg::OSC_PIN2_BIT];

endmodule : port_pin_override_mux

`default_nettype wire

/* File: tb/pin_mux_assertions.sv */
/*
 * Concurrent checks on the pin side of the port override multiplexer.
 * Assumes it is bound to port_pin_override_mux with one clock and async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Checker
// ==========================================================
module pin_mux_assertions
#(
    parameter int WIDTH = 8
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire pin_mux_pkg::pin_override_t [WIDTH-1:0] ovr_i,
    input wire logic deep_sleep_i,
    input wire logic timer2_cmp_a_en_i,
    input wire logic timer1_cmp_a_en_i,
    input wire logic timer1_cmp_b_en_i,
    input wire logic divided_clock_en_i,
    input wire logic divided_clock_out_i,
    input wire logic [WIDTH-1:0] pad_in_i,
    input wire logic [WIDTH-1:0] pad_out_o,
    input wire logic [WIDTH-1:0] pad_oe_o,
    input wire logic [WIDTH-1:0] pullup_en_o,
    input wire logic [WIDTH-1:0] raw_digital_in_o,
    input wire logic [WIDTH-1:0] pin_change_src_o,
    input wire logic [WIDTH-1:0] analog_pad_path_o,
    input wire logic main_osc_pin1_o,
    input wire logic main_osc_pin2_o,
    input wire logic timer_osc_pin1_o,
    input wire logic timer_osc_pin2_o
);
    // Outputs are registered one edge behind their causes, so checks skip the first edge after reset.
    logic up_reg;
    logic up_next;
    logic [WIDTH-1:0] alt_en;
    assign alt_en = WIDTH'({timer2_cmp_a_en_i, timer1_cmp_b_en_i, timer1_cmp_a_en_i, divided_clock_en_i});
    always_comb
    begin
        up_next = 1'b1;
    end
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            up_reg <= 1'b0;
        end
        else
        begin
            up_reg <= up_next;
        end
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i || !up_reg);
    for (genvar g = 0; g < WIDTH; g++)
    begin : g_pin
        a_pullup_ovr:
        assert property ($past(ovr_i[g].pullup_override_en) && !pad_oe_o[g]
            |-> pullup_en_o[g] == $past(ovr_i[g].pullup_override_val)) else $error("pull-up override lost");
        a_dir_ovr:
        assert property ($past(ovr_i[g].dir_override_en) && !$past(alt_en[g])
            |-> pad_oe_o[g] == $past(ovr_i[g].dir_override_val)) else $error("direction override lost");
        a_value_ovr:
        assert property ($past(ovr_i[g].value_override_en) && !$past(alt_en[g]) && pad_oe_o[g]
            |-> pad_out_o[g] == $past(ovr_i[g].value_override_val)) else $error("value override lost");
        a_pad_undriven:
        assert property (pad_oe_o[g] ? !pullup_en_o[g] : !pad_out_o[g]) else $error("idle pad driven");
        a_input_ovr:
        assert property ($past(ovr_i[g].input_en_override_en) |-> raw_digital_in_o[g]
            == ($past(pad_in_i[g]) && $past(ovr_i[g].input_en_override_val))) else $error("input override lost");
        a_input_sleep:
        assert property (!$past(ovr_i[g].input_en_override_en) |-> raw_digital_in_o[g]
            == ($past(pad_in_i[g]) && !$past(deep_sleep_i))) else $error("sleep clamp wrong");
    end
    a_clock_out:
    assert property ($past(divided_clock_en_i) |-> pad_oe_o[0] && pad_out_o[0] == $past(divided_clock_out_i))
        else $error("clock output not forced");
    a_pin_change:
    assert property (pin_change_src_o == raw_digital_in_o) else $error("pin change source differs");
    a_analog_path:
    assert property (analog_pad_path_o == pad_in_i && {main_osc_pin2_o, main_osc_pin1_o} == pad_in_i[7:6]
        && {timer_osc_pin2_o, timer_osc_pin1_o} == pad_in_i[7:6]) else $error("pad path differs");
endmodule : pin_mux_assertions

bind port_pin_override_mux pin_mux_assertions #(.WIDTH(WIDTH)) chk (.clock_i, .resetn_i, .ovr_i, .deep_sleep_i,
    .timer2_cmp_a_en_i, .timer1_cmp_a_en_i, .timer1_cmp_b_en_i, .divided_clock_en_i, .divided_clock_out_i,
    .pad_in_i, .pad_out_o, .pad_oe_o, .pullup_en_o, .raw_digital_in_o, .pin_change_src_o, .analog_pad_path_o,
    .main_osc_pin1_o, .main_osc_pin2_o, .timer_osc_pin1_o, .timer_osc_pin2_o);
`default_nettype wire

/* File: tb/periph_model.sv */
/*
 * Peripheral side: override bundles made in the owners' logic and a resynchronized raw input.
 * Assumes the bench sets a request word per pin; one clock shared with the port.
 */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Peripheral model
// ==========================================================
module periph_model
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire pin_mux_pkg::pin_override_t [7:0] req_i,
    input wire logic [7:0] raw_i,
    output pin_mux_pkg::pin_override_t [7:0] ovr_o,
    output logic [7:0] sync_o
);
    // The raw input is asynchronous to the consumer, so it passes two flops before use.
    logic [7:0] meta_reg;
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ovr_o <= '0;
            meta_reg <= 8'h00;
            sync_o <= 8'h00;
        end
        else
        begin
            ovr_o <= req_i;
            meta_reg <= raw_i;
            sync_o <= meta_reg;
        end
    end
endmodule : periph_model
`default_nettype wire

/* File: tb/port_pin_override_mux_tb_top.sv */
/*
 * Self-checking bench for the port override multiplexer.
 * Assumes zero-wait APB answers and one-cycle registered pin outputs.
 */
`timescale 1ns/1ps
`default_nettype none

module port_pin_override_mux_tb_top;
    // ==========================================================
    // Signals
    // ==========================================================
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000, prdata_o;
    logic pready_o, pslverr_o, deep_sleep_i = 1'b0;
    pin_mux_pkg::pin_override_t [7:0] req = '0, ovr_i;
    logic [7:0] cmp_en = 8'h00, cmp_out = 8'h00, pad_in_i = 8'h00, sync;
    logic [7:0] pad_out_o, pad_oe_o, pullup_en_o, raw_digital_in_o, pin_change_src_o, analog_pad_path_o;
    logic timer1_capture_in_o, spi_mosi_in_o, spi_ss_in_o, main_osc_pin1_o, main_osc_pin2_o;
    logic timer_osc_pin1_o, timer_osc_pin2_o;
    int error_cnt = 0, checks_done = 0;

    port_pin_override_mux uut (.clock_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .ovr_i, .deep_sleep_i, .timer2_cmp_a_en_i(cmp_en[3]),
        .timer2_cmp_a_out_i(cmp_out[3]), .timer1_cmp_a_en_i(cmp_en[1]), .timer1_cmp_a_out_i(cmp_out[1]),
        .timer1_cmp_b_en_i(cmp_en[2]), .timer1_cmp_b_out_i(cmp_out[2]), .divided_clock_en_i(cmp_en[0]),
        .divided_clock_out_i(cmp_out[0]), .pad_in_i, .pad_out_o, .pad_oe_o, .pullup_en_o, .raw_digital_in_o,
        .pin_change_src_o, .timer1_capture_in_o, .spi_mosi_in_o, .spi_ss_in_o, .analog_pad_path_o,
        .main_osc_pin1_o, .main_osc_pin2_o, .timer_osc_pin1_o, .timer_osc_pin2_o);
    periph_model peri (.clock_i, .resetn_i, .req_i(req), .raw_i(raw_digital_in_o), .ovr_o(ovr_i), .sync_o(sync));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        int n;
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= wd;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        check(pready_o, 32'h00000001);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, addr, wd, d, e);
    endtask : wr

    task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, addr, 32'h00000000, d, e);
        check(d, exp);
    endtask : rd

    task automatic settle();
        repeat (3) @(posedge clock_i);
    endtask : settle

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic s_port();
        check(pad_oe_o | pullup_en_o, 32'h00000000);
        rd(pin_mux_pkg::CTRL_OFFSET, 32'h00000000);
        wr(pin_mux_pkg::DIR_OFFSET, 32'h0000000F);
        wr(pin_mux_pkg::LATCH_OFFSET, 32'h00000035);
        settle();
        check(pad_oe_o, 8'h0F);
        check(pad_out_o, 8'h05);
        check(pullup_en_o, 8'h30);
        wr(pin_mux_pkg::CTRL_OFFSET, 32'h00000001);
        settle();
        check(pullup_en_o, 8'h00);
        wr(pin_mux_pkg::SAMPLE_OFFSET, 32'h00000003);
        settle();
        check(pad_out_o, 8'h06);
        rd(pin_mux_pkg::LATCH_OFFSET, 32'h00000036);
    endtask : s_port

    task automatic s_overrides();
        req[1] <= 9'h004;
        @(posedge clock_i);
        req[1] <= '0;
        settle();
        rd(pin_mux_pkg::LATCH_OFFSET, 32'h00000034);
        // Pin 4 forced to drive high, pin 0 forced off, pin 2 value forced low, pin 7 pulled up.
        req[4] <= 9'h078;
        req[0] <= 9'h040;
        req[2] <= 9'h010;
        req[7] <= 9'h180;
        settle();
        check(pad_oe_o, 8'h1E);
        check(pad_out_o, 8'h10);
        check(pullup_en_o, 8'h80);
        req <= '0;
    endtask : s_overrides

    task automatic s_inputs();
        pad_in_i <= 8'hA5;
        settle();
        check(raw_digital_in_o, 8'hA5);
        check(pin_change_src_o, 8'hA5);
        check({timer1_capture_in_o, spi_mosi_in_o, spi_ss_in_o}, 3'b101);
        check(analog_pad_path_o, 8'hA5);
        check({main_osc_pin2_o, main_osc_pin1_o, timer_osc_pin2_o, timer_osc_pin1_o}, 4'hA);
        deep_sleep_i <= 1'b1;
        req[5] <= 9'h003;
        settle();
        settle();
        check(raw_digital_in_o, 8'h20);
        check(sync, 8'h20);
        rd(pin_mux_pkg::STATUS_OFFSET, 32'h00000020);
        rd(pin_mux_pkg::SAMPLE_OFFSET, 32'h00000020);
        deep_sleep_i <= 1'b0;
        req <= '0;
    endtask : s_inputs

    task automatic s_alt();
        logic [31:0] d;
        logic e;
        wr(pin_mux_pkg::DIR_OFFSET, 32'h0000000E);
        cmp_en <= 8'h0F;
        cmp_out <= 8'h0B;
        settle();
        check(pad_oe_o, 8'h0F);
        check(pad_out_o, 8'h0B);
        cmp_en <= 8'h00;
        apb(1'b1, 12'h020, 32'h000000FF, d, e);
        check(e, 32'h00000001);
        apb(1'b0, 12'h020, 32'h00000000, d, e);
        check(e, 32'h00000001);
        check(d, 32'h00000000);
        rd(pin_mux_pkg::DIR_OFFSET, 32'h0000000E);
    endtask : s_alt

    task automatic wrap_up();
        $display("Checks done %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Clock, reset, sequence and watchdog
    // ==========================================================
    initial
    begin
        forever #50 clock_i = ~clock_i;
    end

    initial
    begin
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        s_port();
        s_overrides();
        s_inputs();
        s_alt();
        wrap_up();
    end

    // The sequence needs under a hundred cycles; ten thousand leaves ample margin.
    initial
    begin
        #1000000;
        error_cnt++;
        wrap_up();
    end
endmodule : port_pin_override_mux_tb_top
`default_nettype wire
